// ==== bench/ssef_card_model.sv ====
`timescale 1ns/1ps
// ====================
// Socket card model
// ====================
module ssef_card_model (
    // Bench control
    input wire logic insert_i,
    input wire logic [1:0] cvs_sel_i,
    input wire logic irq_i,
    // Socket pins
    output logic card_irq_o,
    output logic cstschg_o,
    output logic ccd1_n_o,
    output logic ccd2_n_o,
    output logic cvs1_o,
    output logic cvs2_o
);
    // Empty socket: detect and sense lines sit at their pull-up level
    always_comb begin
        ccd1_n_o = ~insert_i;
        ccd2_n_o = ~insert_i;
        cvs1_o = insert_i ? cvs_sel_i[1] : 1'b1;
        cvs2_o = insert_i ? cvs_sel_i[0] : 1'b1;
        // No card, nobody to raise the interrupt pin
        card_irq_o = insert_i & irq_i;
        cstschg_o = 1'b0;
    end
endmodule : ssef_card_model

// ==== bench/ssef_core_bench.sv ====
`timescale 1ns/1ps
module ssef_core_bench;
    // ====================
    // Signals
    // ====================
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    int errors = 0;
    int checks_done = 0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, act = 1'b0, ins = 1'b0, cirq = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0, dat_o, q;
    logic [1:0] vs = 2'h0;
    logic ack, irq, v5, v3, flush, c_irq, c_sts, c_d1, c_d2, c_s1, c_s2;
    // Empty socket, supplies 3.3 V and Y V offered
    localparam logic [31:0] BASE = 32'ha000_0006;
    always #2.5 clk_i = ~clk_i;

    ssef_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .card_irq_i(c_irq), .cstschg_i(c_sts), .ccd1_n_i(c_d1),
        .ccd2_n_i(c_d2), .cvs1_i(c_s1), .cvs2_i(c_s2), .socket_active_i(act),
        .sys_volt_i(4'ha), .vcc5_en_o(v5), .vcc3_en_o(v3), .buf_flush_o(flush), .irq_o(irq));
    ssef_card_model card_u (.insert_i(ins), .cvs_sel_i(vs), .irq_i(cirq), .card_irq_o(c_irq),
        .cstschg_o(c_sts), .ccd1_n_o(c_d1), .ccd2_n_o(c_d2), .cvs1_o(c_s1), .cvs2_o(c_s2));

    // ====================
    // Shared tasks
    // ====================
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One classic cycle; request held until ack is seen high
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        chk("ack", 32'h1, {31'h0, ack});
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        // Idle cycle so the next request starts from a dropped strobe
        @(posedge clk_i);
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rdc(string nm, logic [11:0] a, logic [31:0] m, logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q & m);
    endtask : rdc

    task automatic reset;
        rst_i <= 1'b1;
        tick(10);
        rst_i <= 1'b0;
        tick(1);
    endtask : reset

    // ====================
    // Scenarios
    // ====================
    task automatic t_idle;
        rdc("present", ssef_pkg::OFS_PRESENT, '1, BASE);
        wr(ssef_pkg::OFS_FORCE, 32'hffff_8040);
        rdc("present", ssef_pkg::OFS_PRESENT, '1, BASE);
        rdc("status", ssef_pkg::OFS_EVT_STATUS, '1, 32'h0);
        rdc("force", ssef_pkg::OFS_FORCE, '1, 32'h0);
        rdc("unmapped", 12'h100, '1, 32'h0);
    endtask : t_idle

    // Each forced event alone, then all four with the mask shut
    task automatic t_events;
        wr(ssef_pkg::OFS_EVT_MASK, 32'hf);
        for (int i = 0; i < 4; i++) begin
            wr(ssef_pkg::OFS_FORCE, 32'h1 << i);
            chk("irq", 32'h1, {31'h0, irq});
            rdc("status", ssef_pkg::OFS_EVT_STATUS, '1, 32'h1 << i);
            rdc("present", ssef_pkg::OFS_PRESENT, '1, BASE);
            wr(ssef_pkg::OFS_EVT_STATUS, 32'h1 << i);
            chk("irq", 32'h0, {31'h0, irq});
        end
        wr(ssef_pkg::OFS_EVT_MASK, 32'h0);
        wr(ssef_pkg::OFS_FORCE, 32'hf);
        chk("irq", 32'h0, {31'h0, irq});
        rdc("status", ssef_pkg::OFS_EVT_STATUS, '1, 32'hf);
    endtask : t_events

    task automatic t_flags;
        wr(ssef_pkg::OFS_FORCE, 32'h3b0);
        rdc("present", ssef_pkg::OFS_PRESENT, '1, BASE | 32'h3b0);
        // Data lost clears on read
        rdc("present", ssef_pkg::OFS_PRESENT, '1, BASE | 32'h2b0);
    endtask : t_flags

    // CardBus 3.3 V card: decode, bad request, lock, retest, removal
    task automatic t_card;
        int n;
        reset();
        ins <= 1'b1;
        vs <= 2'b10;
        tick(210);
        rdc("caps", ssef_pkg::OFS_PRESENT, 32'h3ff0, 32'h0820);
        // Only an inserted card can drive its interrupt pin
        cirq <= 1'b1;
        rdc("card irq", ssef_pkg::OFS_PRESENT, 32'h40, 32'h40);
        cirq <= 1'b0;
        rdc("card irq", ssef_pkg::OFS_PRESENT, 32'h40, 32'h0);
        wr(ssef_pkg::OFS_FORCE, 32'hb0);
        rdc("caps", ssef_pkg::OFS_PRESENT, 32'h3ff0, 32'h0820);
        wr(ssef_pkg::OFS_SOCK_CTRL, 32'h20);
        tick(3);
        rdc("bad vcc", ssef_pkg::OFS_PRESENT, 32'h3ff0, 32'h0a20);
        chk("vcc5", 32'h0, {31'h0, v5});
        wr(ssef_pkg::OFS_SOCK_CTRL, 32'h30);
        tick(3);
        chk("vcc3", 32'h1, {31'h0, v3});
        wr(ssef_pkg::OFS_SOCK_CTRL, 32'h0);
        wr(ssef_pkg::OFS_FORCE, 32'h800);
        wr(ssef_pkg::OFS_SOCK_CTRL, 32'h30);
        tick(5);
        chk("vcc3", 32'h0, {31'h0, v3});
        wr(ssef_pkg::OFS_FORCE, 32'h4000);
        tick(210);
        wr(ssef_pkg::OFS_SOCK_CTRL, 32'h30);
        tick(3);
        chk("vcc3", 32'h1, {31'h0, v3});
        act <= 1'b1;
        ins <= 1'b0;
        n = 0;
        repeat (6) begin
            @(posedge clk_i);
            if (flush === 1'b1) n++;
        end
        chk("flush", 32'h1, n);
        act <= 1'b0;
        rdc("lost", ssef_pkg::OFS_PRESENT, 32'h100, 32'h100);
    endtask : t_card

    task automatic t_notcard;
        reset();
        ins <= 1'b1;
        vs <= 2'b00;
        tick(210);
        rdc("notcard", ssef_pkg::OFS_PRESENT, 32'h3ff0, 32'h80);
        wr(ssef_pkg::OFS_SOCK_CTRL, 32'h20);
        tick(3);
        chk("vcc5", 32'h0, {31'h0, v5});
        reset();
        rdc("flags", ssef_pkg::OFS_PRESENT, 32'h3f80, 32'h0);
    endtask : t_notcard

    // ====================
    // Run and verdict
    // ====================
    task automatic end_sim;
        if (errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    initial begin
        reset();
        t_idle();
        t_events();
        t_flags();
        t_card();
        t_notcard();
        end_sim();
    end

    // Whole run needs about 850 cycles
    initial begin
        tick(8000);
        errors++;
        end_sim();
    end
endmodule : ssef_core_bench

// ==== common/ssef_pkg.sv ====
//==================================================================
// Socket state and event force constants
//==================================================================
// Operation
// - Card interrupt flag follows card pin, unregistered
// - Unsupported card flag set; power refused meanwhile
// - Removal while active: data lost, buffers flushed
// - Bad supply request on CardBus sets flag
// - Voltage test sets card voltage capability flags
// - Reset clears status and card voltage flags
// - Bits 31:28 show system supply availability
// - Force register stores nothing, momentary only
// - Force one sets event and/or state bit
// - Forced events 3:0 raise masked interrupt
// - Force bits 3:0 touch event status only
// - Force 4,5,7 ignored while card installed
// - Force 8,9 set data lost, bad request
// - Forced voltage flag blocks power until retest
// - Force bit 14 starts card voltage retest
// - New card insertion starts test automatically
package ssef_pkg;

    //==============================================================
    // Register byte offsets
    //==============================================================
    localparam logic [11:0] OFS_EVT_STATUS = 12'h000;
    localparam logic [11:0] OFS_EVT_MASK = 12'h004;
    localparam logic [11:0] OFS_PRESENT = 12'h008;
    localparam logic [11:0] OFS_FORCE = 12'h00c;
    localparam logic [11:0] OFS_SOCK_CTRL = 12'h010;

    //==============================================================
    // Field positions
    //==============================================================
    localparam int B_CSTS = 0;
    localparam int B_CCD1 = 1;
    localparam int B_CCD2 = 2;
    localparam int B_PWR = 3;
    localparam int B_16BIT = 4;
    localparam int B_CBUS = 5;
    localparam int B_IRQ = 6;
    localparam int B_NOTCARD = 7;
    localparam int B_LOST = 8;
    localparam int B_BADVCC = 9;
    localparam int B_V5 = 10;
    localparam int B_V33 = 11;
    localparam int B_VX = 12;
    localparam int B_VY = 13;
    localparam int B_RETEST = 14;
    localparam int B_SYSV = 28;
    localparam int B_VCC_SEL = 4;

    //==============================================================
    // Reset values and encodings
    //==============================================================
    localparam logic [3:0] EVT_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [2:0] VCC_OFF = 3'h0;
    localparam logic [2:0] VCC_5V = 3'h2;
    localparam logic [2:0] VCC_3V3 = 3'h3;

    //==============================================================
    // Timing
    //==============================================================
    localparam int CLK_MHZ = 200;
    localparam int SETTLE_NS = 1000;  // Sense line settling before decode
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int PWRUP_CYC = 256;   // Supply on to power cycle complete

    //==============================================================
    // Card decode result
    //==============================================================
    typedef struct packed {
        logic is16;
        logic is32;
        logic notcard;
        logic v5;
        logic v33;
        logic vx;
        logic vy;
    } ssef_caps_t;

    // Voltage test sequencer
    typedef enum logic [1:0] {
        SSEF_IDLE,
        SSEF_SETTLE,
        SSEF_DONE
    } ssef_test_t;

endpackage : ssef_pkg

// ==== core/ssef_core.sv ====
`timescale 1ns/1ps
module ssef_core (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Card side pins
    input wire logic card_irq_i,
    input wire logic cstschg_i,
    input wire logic ccd1_n_i,
    input wire logic ccd2_n_i,
    input wire logic cvs1_i,
    input wire logic cvs2_i,
    input wire logic socket_active_i,
    // System supply straps
    input wire logic [3:0] sys_volt_i,
    // Socket power and buffer control
    output logic vcc5_en_o,
    output logic vcc3_en_o,
    output logic buf_flush_o,
    // Interrupt
    output logic irq_o
);

    //==============================================================
    // Helpers
    //==============================================================
    // Decode sense lines into card type and voltages
    function automatic ssef_pkg::ssef_caps_t decode_caps(input logic s1, input logic s2);
        ssef_pkg::ssef_caps_t c;
        c = '0;
        // 11: 16-bit 5 V; 01: 16-bit 5 V and 3.3 V; 10: CardBus 3.3 V; 00: no card
        c.is16 = s2;
        c.v5 = s2;
        c.v33 = s1 ^ s2;
        c.is32 = s1 && !s2;
        c.notcard = !s1 && !s2;
        return c;
    endfunction : decode_caps

    //==============================================================
    // Bus decode
    //==============================================================
    logic ack_reg;                  // Answer flop, one cycle after request
    logic [31:0] dat_reg;           // Read data flop
    logic req;                      // New request this cycle
    logic wr;                       // Write request
    logic [31:0] wmask;             // Data qualified by lanes
    logic [31:0] force_w;           // Momentary force pulses, never stored
    logic rd_present;               // Read of present state this cycle
    logic [31:0] lanes;             // Byte-lane enables from select
    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr = req && wb_we_i;
    assign lanes = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wmask = wb_dat_i & lanes;
    // Phantom register: write data acts only in the cycle it is taken
    assign force_w = (wr && wb_adr_i == ssef_pkg::OFS_FORCE) ? wmask : 32'h0;
    assign rd_present = req && !wb_we_i && wb_adr_i == ssef_pkg::OFS_PRESENT;

    //==============================================================
    // Card presence and pin history
    //==============================================================
    logic present;                  // Both detect lines low
    logic present_q_reg;
    logic ccd1_q_reg;
    logic ccd2_q_reg;
    logic csts_q_reg;
    logic inserted;
    logic removed;
    assign present = !ccd1_n_i && !ccd2_n_i;
    assign inserted = present && !present_q_reg;
    assign removed = !present && present_q_reg;

    // Previous pin levels for edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            present_q_reg <= 1'b0;
            ccd1_q_reg <= 1'b1;
            ccd2_q_reg <= 1'b1;
            csts_q_reg <= 1'b0;
        end else begin
            present_q_reg <= present;
            ccd1_q_reg <= ccd1_n_i;
            ccd2_q_reg <= ccd2_n_i;
            csts_q_reg <= cstschg_i;
        end
    end

    //==============================================================
    // Card voltage test sequencer
    //==============================================================
    ssef_pkg::ssef_test_t test_reg;
    logic [15:0] settle_cnt_reg;
    logic test_start;
    ssef_pkg::ssef_caps_t caps;
    // Insertion or software retest both launch a fresh decode
    assign test_start = inserted || force_w[ssef_pkg::B_RETEST];
    assign caps = decode_caps(cvs1_i, cvs2_i);

    // Settle the sense lines, then latch the decode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            test_reg <= ssef_pkg::SSEF_IDLE;
            settle_cnt_reg <= 16'h0;
        end else if (test_start) begin
            test_reg <= ssef_pkg::SSEF_SETTLE;
            settle_cnt_reg <= 16'(ssef_pkg::SETTLE_CYC - 1);
        end else begin
            unique case (test_reg)
                ssef_pkg::SSEF_IDLE: begin
                    settle_cnt_reg <= 16'h0;
                end
                ssef_pkg::SSEF_SETTLE: begin
                    // Card pulled mid-test: give up quietly
                    if (!present) begin
                        test_reg <= ssef_pkg::SSEF_IDLE;
                    end else if (settle_cnt_reg == 16'h0) begin
                        test_reg <= ssef_pkg::SSEF_DONE;
                    end else begin
                        settle_cnt_reg <= settle_cnt_reg - 16'h1;
                    end
                end
                ssef_pkg::SSEF_DONE: begin
                    test_reg <= ssef_pkg::SSEF_IDLE;
                end
            endcase
        end
    end

    //==============================================================
    // Card type and voltage flags
    //==============================================================
    logic is16_reg;
    logic is32_reg;
    logic notcard_reg;
    logic [3:0] cardv_reg;          // {Y, X, 3.3, 5}
    logic lock_reg;                 // Power blocked after forced voltage
    logic test_done;
    logic force_ok;                 // Type forcing allowed only when empty
    assign test_done = test_reg == ssef_pkg::SSEF_DONE;
    assign force_ok = !present;

    // Type flags: decode result wins, forcing only with empty socket
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            is16_reg <= 1'b0;
            is32_reg <= 1'b0;
            notcard_reg <= 1'b0;
        end else if (test_done) begin
            is16_reg <= caps.is16;
            is32_reg <= caps.is32;
            notcard_reg <= caps.notcard;
        end else if (force_ok) begin
            is16_reg <= is16_reg | force_w[ssef_pkg::B_16BIT];
            is32_reg <= is32_reg | force_w[ssef_pkg::B_CBUS];
            notcard_reg <= notcard_reg | force_w[ssef_pkg::B_NOTCARD];
        end
    end

    // Voltage flags: set by the test, or forced which locks power
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cardv_reg <= 4'h0;
            lock_reg <= 1'b0;
        end else if (test_done) begin
            cardv_reg <= {caps.vy, caps.vx, caps.v33, caps.v5};
            lock_reg <= 1'b0;
        end else begin
            cardv_reg <= cardv_reg | force_w[ssef_pkg::B_VY:ssef_pkg::B_V5];
            if (|force_w[ssef_pkg::B_VY:ssef_pkg::B_V5]) begin
                lock_reg <= 1'b1;
            end
        end
    end

    //==============================================================
    // Socket power control
    //==============================================================
    logic [2:0] vcc_sel_reg;        // Software supply request
    logic vcc5_reg;
    logic vcc3_reg;
    logic [8:0] pwr_cnt_reg;
    logic pwr_done_reg;
    logic req_ok;                   // Request supported by card and system
    logic req_on;
    assign req_on = vcc_sel_reg == ssef_pkg::VCC_5V || vcc_sel_reg == ssef_pkg::VCC_3V3;
    assign req_ok = (vcc_sel_reg == ssef_pkg::VCC_5V && cardv_reg[0] && sys_volt_i[0])
        || (vcc_sel_reg == ssef_pkg::VCC_3V3 && cardv_reg[1] && sys_volt_i[1]);

    // Supply select register, cleared on removal
    always_ff @(posedge clk_i) begin
        if (rst_i || removed) begin
            vcc_sel_reg <= ssef_pkg::VCC_OFF;
        end else if (wr && wb_adr_i == ssef_pkg::OFS_SOCK_CTRL && wb_sel_i[0]) begin
            vcc_sel_reg <= wb_dat_i[ssef_pkg::B_VCC_SEL +: 3];
        end
    end

    // Apply supply only for a legal, unlocked, supported card
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vcc5_reg <= 1'b0;
            vcc3_reg <= 1'b0;
        end else if (!present || notcard_reg || !req_ok) begin
            vcc5_reg <= 1'b0;
            vcc3_reg <= 1'b0;
        end else if (!lock_reg) begin
            vcc5_reg <= vcc_sel_reg == ssef_pkg::VCC_5V;
            vcc3_reg <= vcc_sel_reg == ssef_pkg::VCC_3V3;
        end
    end

    // Power cycle completes a fixed count after the supply comes up
    always_ff @(posedge clk_i) begin
        if (rst_i || !(vcc5_reg || vcc3_reg)) begin
            pwr_cnt_reg <= 9'h0;
            pwr_done_reg <= 1'b0;
        end else if (pwr_cnt_reg == 9'(ssef_pkg::PWRUP_CYC - 1)) begin
            pwr_done_reg <= 1'b1;
        end else begin
            pwr_cnt_reg <= pwr_cnt_reg + 9'h1;
        end
    end

    //==============================================================
    // Data lost and bad supply flags
    //==============================================================
    logic lost_reg;
    logic bad_reg;
    logic flush_reg;
    logic pull_active;
    logic bad_req;
    assign pull_active = removed && socket_active_i;
    assign bad_req = present && is32_reg && req_on && !req_ok;

    // Set wins over the clear-on-read of the present state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lost_reg <= 1'b0;
            bad_reg <= 1'b0;
            flush_reg <= 1'b0;
        end else begin
            flush_reg <= pull_active;
            if (pull_active || force_w[ssef_pkg::B_LOST]) begin
                lost_reg <= 1'b1;
            end else if (rd_present) begin
                lost_reg <= 1'b0;
            end
            if (bad_req || force_w[ssef_pkg::B_BADVCC]) begin
                bad_reg <= 1'b1;
            end
        end
    end

    //==============================================================
    // Event status, mask and interrupt
    //==============================================================
    logic [3:0] evt_reg;
    logic [3:0] mask_reg;
    logic [3:0] evt_set;
    logic [3:0] evt_clr;
    logic pwr_done_q_reg;
    logic irq_reg;
    // Hardware events plus forced events, which leave present state alone
    assign evt_set = {pwr_done_reg && !pwr_done_q_reg,
                      ccd2_n_i != ccd2_q_reg,
                      ccd1_n_i != ccd1_q_reg,
                      cstschg_i && !csts_q_reg} | force_w[3:0];
    assign evt_clr = (wr && wb_adr_i == ssef_pkg::OFS_EVT_STATUS) ? wmask[3:0] : 4'h0;
    // Sticky bits, write one to clear; a new event beats the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_reg <= ssef_pkg::EVT_RESET;
            pwr_done_q_reg <= 1'b0;
        end else begin
            evt_reg <= (evt_reg & ~evt_clr) | evt_set;
            pwr_done_q_reg <= pwr_done_reg;
        end
    end

    // Mask register; survives removal, so software need not rearm it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= ssef_pkg::MASK_RESET;
        end else if (wr && wb_adr_i == ssef_pkg::OFS_EVT_MASK) begin
            mask_reg <= (mask_reg & ~lanes[3:0]) | wmask[3:0];
        end
    end

    // Level interrupt, one flop behind the status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(evt_reg & mask_reg);
        end
    end

    //==============================================================
    // Read path and acknowledge
    //==============================================================
    logic [31:0] present_w;
    // Card interrupt comes straight from the pin, no flop in between
    always_comb begin
        present_w = 32'h0;
        present_w[ssef_pkg::B_CSTS] = cstschg_i;
        present_w[ssef_pkg::B_CCD1] = ccd1_n_i;
        present_w[ssef_pkg::B_CCD2] = ccd2_n_i;
        present_w[ssef_pkg::B_PWR] = pwr_done_reg;
        present_w[ssef_pkg::B_16BIT] = is16_reg;
        present_w[ssef_pkg::B_CBUS] = is32_reg;
        present_w[ssef_pkg::B_IRQ] = card_irq_i;
        present_w[ssef_pkg::B_NOTCARD] = notcard_reg;
        present_w[ssef_pkg::B_LOST] = lost_reg;
        present_w[ssef_pkg::B_BADVCC] = bad_reg;
        present_w[ssef_pkg::B_VY:ssef_pkg::B_V5] = cardv_reg;
        present_w[31:ssef_pkg::B_SYSV] = sys_volt_i;
    end

    // One-cycle answer; unmapped and write-only offsets read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end else begin
            ack_reg <= req;
            if (req && !wb_we_i) begin
                unique case (wb_adr_i)
                    ssef_pkg::OFS_EVT_STATUS: dat_reg <= {28'h0, evt_reg};
                    ssef_pkg::OFS_EVT_MASK: dat_reg <= {28'h0, mask_reg};
                    ssef_pkg::OFS_PRESENT: dat_reg <= present_w;
                    ssef_pkg::OFS_SOCK_CTRL: dat_reg <= {25'h0, vcc_sel_reg, 4'h0};
                    default: dat_reg <= 32'h0;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign vcc5_en_o = vcc5_reg;
    assign vcc3_en_o = vcc3_reg;
    assign buf_flush_o = flush_reg;
    assign irq_o = irq_reg;

    //==============================================================
    // Checks
    //==============================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_irq_mirror: assert property (present_w[6] == card_irq_i)
        else $error("card interrupt flag does not follow pin");
    chk_notcard_nopwr: assert property (notcard_reg |=> !vcc5_en_o && !vcc3_en_o)
        else $error("power applied to unsupported card");
    chk_lost_flush: assert property (pull_active |=> lost_reg && buf_flush_o)
        else $error("removal while active not flagged");
    chk_bad_request: assert property (bad_req |=> bad_reg)
        else $error("bad supply request not flagged");
    chk_test_caps: assert property (test_done |=> cardv_reg ==
        {2'h0, $past(cvs1_i ^ cvs2_i), $past(cvs2_i)})
        else $error("voltage flags not loaded from test");
    chk_reset_clear: assert property (@(posedge clk_i) $past(rst_i) |->
        !notcard_reg && !lost_reg && !bad_reg && cardv_reg == 4'h0)
        else $error("flags not cleared by reset");
    chk_sys_volt: assert property (present_w[31:28] == sys_volt_i)
        else $error("system voltage bits wrong");
    chk_force_reads0: assert property (req && !wb_we_i && wb_adr_i == ssef_pkg::OFS_FORCE
        |=> wb_ack_o && wb_dat_o == 32'h0)
        else $error("force register returned data");
    chk_force_evt: assert property (force_w[0] |=> evt_reg[0])
        else $error("forced event not set");
    chk_evt_irq: assert property (|(evt_reg & mask_reg) |=> irq_o)
        else $error("masked event gave no interrupt");
    chk_force_noside: assert property (|force_w[3:0] && force_w[13:4] == 10'h0
        && !test_done |=> $stable(is16_reg) && $stable(notcard_reg) && $stable(cardv_reg))
        else $error("event force touched present state");
    chk_force_ignored: assert property (present && !test_done && force_w[4] |=>
        is16_reg == $past(is16_reg))
        else $error("type force not ignored with card in");
    chk_force_lost: assert property (force_w[8] |=> lost_reg)
        else $error("data lost force not applied");
    chk_lock_power: assert property (lock_reg && !vcc5_en_o && !vcc3_en_o && !test_done
        |=> !vcc5_en_o && !vcc3_en_o)
        else $error("power rose while voltage locked");
    chk_retest_start: assert property (force_w[14] |=> test_reg == ssef_pkg::SSEF_SETTLE)
        else $error("retest did not start");
    chk_insert_test: assert property (inserted |=> test_reg == ssef_pkg::SSEF_SETTLE)
        else $error("insertion did not start test");
    chk_reserved_zero: assert property (present_w[27:14] == 14'h0)
        else $error("reserved state bits not zero");
endmodule : ssef_core
